//--- rtl/sfc_pkg.sv
// Purpose: constants for the serial command front end of a ferroelectric memory
// Assumes: host runs serial mode 0 or 3, pins sampled by a 50 MHz clock
// Notes: status byte = guard(7), spare(6:4), block guards(3:2), latch(1), zero(0)
`default_nettype none

package sfc_pkg;

  // ----------------------------------------
  // op-codes
  // ----------------------------------------
  localparam logic [7:0] cmd_set_write_latch = 8'h06;
  localparam logic [7:0] cmd_clear_write_latch = 8'h04;
  localparam logic [7:0] cmd_status_read = 8'h05;
  localparam logic [7:0] cmd_status_write = 8'h01;
  localparam logic [7:0] cmd_array_read = 8'h03;
  localparam logic [7:0] cmd_array_write = 8'h02;
  localparam logic [7:0] cmd_fast_array_read = 8'h0b;
  localparam logic [7:0] cmd_deep_sleep = 8'hba;
  localparam logic [7:0] cmd_hibernate = 8'hb9;
  localparam logic [7:0] cmd_device_id_read = 8'h9f;
  localparam logic [7:0] cmd_unique_id_read = 8'h4c;
  localparam logic [7:0] cmd_serial_number_write = 8'hc2;
  localparam logic [7:0] cmd_serial_number_read = 8'hc3;
  localparam logic [7:0] cmd_special_sector_write = 8'h42;
  localparam logic [7:0] cmd_special_sector_read = 8'h4b;
  localparam logic [7:0] cmd_special_sector_fast_read = 8'h49;

  // ----------------------------------------
  // status fields and reset values
  // ----------------------------------------
  localparam int status_write_guard = 5;
  localparam int block_guard_hi = 1;
  localparam int block_guard_lo = 0;
  localparam int nv_lsb = 2;
  localparam logic [5:0] nv_reset = 6'h00;
  localparam logic write_latch_reset = 1'b0;

  // ----------------------------------------
  // pins, widths, fifo
  // ----------------------------------------
  localparam int pin_cs = 4;
  localparam int pin_sck = 3;
  localparam int pin_si = 2;
  localparam int pin_hold = 1;
  localparam int pin_wp = 0;
  localparam int pin_count = 5;
  localparam logic [4:0] pin_idle = 5'h13;
  localparam logic [2:0] last_bit = 3'h7;
  localparam int code_width = 8;
  localparam int fifo_depth = 4;

  typedef enum logic [2:0] {
    st_idle,
    st_opcode,
    st_status_read,
    st_status_write,
    st_pass,
    st_ignore
  } sfc_state_e;

endpackage

`default_nettype wire

//--- rtl/sfc_front_end.sv
// Purpose: serial slave front end: pins, op-code decode, status byte, command queue
// Assumes: pins arrive asynchronously, clk much faster than the serial clock
// Notes: decoded commands leave through a small queue for the array side
`default_nettype none

// ----------------------------------------
// command queue
// ----------------------------------------
module sfc_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] full_count = D[AW:0];
  localparam logic [AW:0] one_count = {{AW{1'b0}}, 1'b1};
  localparam logic [AW-1:0] one_ptr = {{(AW-1){1'b0}}, 1'b1};

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] cnt_reg;
  logic [AW:0] cnt_next;
  logic valid_reg;
  logic [W-1:0] head_reg;
  wire push = in_valid && in_ready;
  wire pop = valid_reg && out_ready;
  wire [AW-1:0] rd_ptr_next = pop ? rd_ptr_reg + one_ptr : rd_ptr_reg;
  // head loaded ahead so the queue output leaves a flop
  wire [W-1:0] head_next = (push && wr_ptr_reg == rd_ptr_next) ? in_data : mem[rd_ptr_next];

  assign in_ready = cnt_reg != full_count;
  assign out_valid = valid_reg;
  assign out_data = head_reg;
  assign cnt_next = cnt_reg + (push ? one_count : '0) - (pop ? one_count : '0);

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
      valid_reg <= 1'b0;
      head_reg <= '0;
    end else if (ce) begin
      wr_ptr_reg <= push ? wr_ptr_reg + one_ptr : wr_ptr_reg;
      rd_ptr_reg <= rd_ptr_next;
      cnt_reg <= cnt_next;
      valid_reg <= cnt_next != '0;
      head_reg <= (cnt_next != '0) ? head_next : head_reg;
    end
  end
endmodule

// ----------------------------------------
// front end top
// ----------------------------------------
module sfc_front_end (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // serial pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so_out,
  output logic so_oe_n,
  // status view
  output logic [7:0] status_out,
  output logic sleeping,
  // decoded command queue
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  input wire logic cmd_ready
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [4:0] pin_raw = {cs_n, sck, si, hold_n, wp_n};
  logic [4:0] s1_reg;
  logic [4:0] s2_reg;
  logic [4:0] s3_reg;
  logic [4:0] filt_reg;
  logic [4:0] prev_reg;

  genvar g;
  generate
    for (g = 0; g < sfc_pkg::pin_count; g++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!nrst) begin
          s1_reg[g] <= sfc_pkg::pin_idle[g];
          s2_reg[g] <= sfc_pkg::pin_idle[g];
          s3_reg[g] <= sfc_pkg::pin_idle[g];
          filt_reg[g] <= sfc_pkg::pin_idle[g];
          prev_reg[g] <= sfc_pkg::pin_idle[g];
        end else if (ce) begin
          s1_reg[g] <= pin_raw[g];
          s2_reg[g] <= s1_reg[g];
          s3_reg[g] <= s2_reg[g];
          filt_reg[g] <= (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : filt_reg[g];
          prev_reg[g] <= filt_reg[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // edges and pin levels
  // ----------------------------------------
  wire sel = !filt_reg[sfc_pkg::pin_cs];
  wire held = !filt_reg[sfc_pkg::pin_hold];
  wire live = sel && !held;
  wire sck_now = filt_reg[sfc_pkg::pin_sck];
  wire sck_was = prev_reg[sfc_pkg::pin_sck];
  wire sck_rise = live && sck_now && !sck_was;
  wire sck_fall = live && !sck_now && sck_was;
  wire cs_fall = sel && prev_reg[sfc_pkg::pin_cs];
  wire cs_rise = !sel && !prev_reg[sfc_pkg::pin_cs];
  wire si_bit = filt_reg[sfc_pkg::pin_si];
  wire wp_low = !filt_reg[sfc_pkg::pin_wp];

  // ----------------------------------------
  // state and registers
  // ----------------------------------------
  sfc_pkg::sfc_state_e state_reg;
  sfc_pkg::sfc_state_e state_next;
  logic [2:0] bit_cnt_reg;
  logic [2:0] bit_cnt_next;
  logic [7:0] shift_reg;
  logic [5:0] nv_reg;
  logic [5:0] nv_next;
  logic wlatch_reg;
  logic wlatch_next;
  logic sleep_reg;
  logic arm_reg;
  logic pend_reg;
  logic [7:0] pend_code_reg;
  logic so_reg;
  logic so_oe_n_reg;
  logic fifo_in_ready;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire [7:0] shift_in = {shift_reg[6:0], si_bit};
  wire byte_done = sck_rise && (bit_cnt_reg == sfc_pkg::last_bit);
  wire op_done = (state_reg == sfc_pkg::st_opcode) && byte_done;
  wire [7:0] status_word = {nv_reg, wlatch_reg, 1'b0};
  wire is_set = shift_in == sfc_pkg::cmd_set_write_latch;
  wire is_clr = shift_in == sfc_pkg::cmd_clear_write_latch;
  wire is_srd = shift_in == sfc_pkg::cmd_status_read;
  wire is_swr = shift_in == sfc_pkg::cmd_status_write;
  wire is_arr = shift_in == sfc_pkg::cmd_array_read
    || shift_in == sfc_pkg::cmd_fast_array_read;
  wire is_awr = shift_in == sfc_pkg::cmd_array_write;
  wire is_nap = shift_in == sfc_pkg::cmd_deep_sleep
    || shift_in == sfc_pkg::cmd_hibernate;
  wire is_ssr = shift_in == sfc_pkg::cmd_special_sector_read
    || shift_in == sfc_pkg::cmd_special_sector_fast_read;
  wire is_ssw = shift_in == sfc_pkg::cmd_special_sector_write;
  wire is_id = shift_in == sfc_pkg::cmd_device_id_read
    || shift_in == sfc_pkg::cmd_unique_id_read
    || shift_in == sfc_pkg::cmd_serial_number_read;
  wire is_snw = shift_in == sfc_pkg::cmd_serial_number_write;
  wire is_known = is_set || is_clr || is_srd || is_swr || is_arr || is_awr
    || is_nap || is_ssr || is_ssw || is_id || is_snw;
  wire is_write = is_awr || is_ssw || is_snw || is_swr;
  wire push_cmd = op_done && is_known && !(is_write && !wlatch_reg);
  wire guard_on = nv_reg[sfc_pkg::status_write_guard] && wp_low;
  wire swr_commit = (state_reg == sfc_pkg::st_status_write) && byte_done;
  wire swr_ok = wlatch_reg && !guard_on;
  wire so_drive = (state_reg == sfc_pkg::st_status_read) && live;

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    if (cs_rise) begin
      state_next = sfc_pkg::st_idle;
    end else if (cs_fall) begin
      state_next = (sleep_reg || pend_reg) ? sfc_pkg::st_ignore : sfc_pkg::st_opcode;
    end else if (op_done) begin
      case (1'b1)
        is_srd: state_next = sfc_pkg::st_status_read;
        is_swr: state_next = sfc_pkg::st_status_write;
        default: state_next = sfc_pkg::st_pass;
      endcase
    end else if (swr_commit) begin
      state_next = sfc_pkg::st_pass;
    end
  end

  always_comb begin
    bit_cnt_next = bit_cnt_reg;
    if (cs_fall || cs_rise) begin
      bit_cnt_next = '0;
    end else if (sck_rise) begin
      bit_cnt_next = bit_cnt_reg + 3'h1;
    end
  end

  always_comb begin
    wlatch_next = wlatch_reg;
    if (cs_fall && sleep_reg) begin
      wlatch_next = 1'b0;
    end else if (op_done && is_set) begin
      wlatch_next = 1'b1;
    end else if (op_done && is_clr) begin
      wlatch_next = 1'b0;
    end
  end

  // status write keeps the latch and drops input bits 1 and 0
  assign nv_next = (swr_commit && swr_ok)
    ? shift_in[7:sfc_pkg::nv_lsb] : nv_reg;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= sfc_pkg::st_idle;
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      nv_reg <= sfc_pkg::nv_reset;
      wlatch_reg <= sfc_pkg::write_latch_reset;
    end else if (ce) begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= sck_rise ? shift_in : shift_reg;
      nv_reg <= nv_next;
      wlatch_reg <= wlatch_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sleep_reg <= 1'b0;
      arm_reg <= 1'b0;
    end else if (ce) begin
      arm_reg <= cs_rise ? 1'b0 : (arm_reg || (op_done && is_nap));
      sleep_reg <= cs_rise ? arm_reg : (sleep_reg && !cs_fall);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pend_reg <= 1'b0;
      pend_code_reg <= '0;
    end else if (ce) begin
      pend_reg <= push_cmd || (pend_reg && !fifo_in_ready);
      pend_code_reg <= push_cmd ? shift_in : pend_code_reg;
    end
  end

  // output pin shifts MSB first on falling clock, repeats while selected
  always_ff @(posedge clk) begin
    if (!nrst) begin
      so_reg <= 1'b0;
      so_oe_n_reg <= 1'b1;
    end else if (ce) begin
      so_reg <= (sck_fall && so_drive)
        ? status_word[sfc_pkg::last_bit - bit_cnt_reg] : so_reg;
      so_oe_n_reg <= !so_drive;
    end
  end

  assign so_out = so_reg;
  assign so_oe_n = so_oe_n_reg;
  assign status_out = status_word;
  assign sleeping = sleep_reg;

  // ----------------------------------------
  // command queue
  // ----------------------------------------
  sfc_fifo #(
    .W(sfc_pkg::code_width),
    .D(sfc_pkg::fifo_depth)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .in_valid(pend_reg),
    .in_data(pend_code_reg),
    .in_ready(fifo_in_ready),
    .out_valid(cmd_valid),
    .out_data(cmd_code),
    .out_ready(cmd_ready)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst || !ce);

  desel_float_a: assert property (
    !sel |=> so_oe_n_reg)
    else $error("output driven while deselected");

  hold_float_a: assert property (
    sel && held |=> so_oe_n_reg && $stable(shift_reg))
    else $error("hold did not pause the link");

  latch_set_a: assert property (
    op_done && is_set && !(cs_fall && sleep_reg) |=> wlatch_reg)
    else $error("set command left latch clear");

  latch_clear_a: assert property (
    op_done && is_clr |=> !wlatch_reg)
    else $error("clear command left latch set");

  zero_bit_a: assert property (
    status_out[0] == 1'b0 ##1 status_out[0] == 1'b0)
    else $error("status bit 0 not zero");

  swr_keep_a: assert property (
    swr_commit |=> wlatch_reg == $past(wlatch_reg))
    else $error("status write changed latch");

  swr_refuse_a: assert property (
    swr_commit && !swr_ok |=> $stable(nv_reg))
    else $error("refused status write took effect");

  swr_store_a: assert property (
    swr_commit && swr_ok |=> status_out[7:2] == $past(shift_in[7:2]))
    else $error("status write stored wrong bits");

  partial_code_a: assert property (
    cs_rise |=> (state_reg == sfc_pkg::st_idle && !$rose(pend_reg)) [*2])
    else $error("partial op-code not discarded");

  so_edge_a: assert property (
    $changed(so_out) |-> $past(sck_fall))
    else $error("output changed off falling edge");

  latch_wake_a: assert property (
    cs_fall && sleep_reg |=> !wlatch_reg && !sleep_reg)
    else $error("wake frame left latch or sleep set");

  guard_block_a: assert property (
    swr_commit && guard_on |=> $stable(nv_reg))
    else $error("guarded status write took effect");

  write_refuse_a: assert property (
    op_done && is_write && !wlatch_reg |=> !pend_reg)
    else $error("write op-code queued with latch clear");

endmodule

`default_nettype wire

//--- dv/sfc_host.sv
// Purpose: serial host model driving the front end pins
// Assumes: 160 ns serial clock, 8 system clocks per bit
// Notes: a floated output line reads as the inverse of its last value
`default_nettype none

module sfc_host (
  // system clock
  input wire logic clk,
  // serial pins
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  output logic wp_n,
  input wire logic so_out,
  input wire logic so_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic so_last = 1'b0;
  logic so_line;
  logic m3 = 1'b0;

  // ----------------------------------------
  // line seen by the host
  // ----------------------------------------
  assign so_line = so_oe_n ? ~so_last : so_out;
  always @(posedge clk) if (!so_oe_n) so_last <= so_out;

  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    wp_n = 1'b1;
  end

  // ----------------------------------------
  // pin sequences
  // ----------------------------------------
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic set_wp(input logic v);
    wp_n = v;
    wt(4);
  endtask

  task automatic start(input logic mode3);
    m3 = mode3;
    sck = mode3;
    wt(2);
    cs_n = 1'b0;
    wt(6);
  endtask

  task automatic stop();
    wt(4);
    cs_n = 1'b1;
    si = ~si;
    wt(12);
  endtask

  task automatic nib(input logic [3:0] n, output logic [3:0] r);
    for (int i = 3; i >= 0; i--) begin
      if (m3) sck = 1'b0;
      si = n[i];
      wt(4);
      sck = 1'b1;
      wt(4);
      r[i] = so_line;
      if (!m3) sck = 1'b0;
    end
  endtask

  task automatic pause();
    hold_n = 1'b0;
    wt(4);
    sck = ~sck;
    si = ~si;
    wt(4);
    sck = ~sck;
    wt(6);
    hold_n = 1'b1;
    wt(4);
  endtask

  task automatic byte_x(input logic [7:0] b, output logic [7:0] r);
    nib(b[7:4], r[7:4]);
    nib(b[3:0], r[3:0]);
  endtask

  task automatic cmd(input logic mode3, input logic [7:0] op, input logic [7:0] d,
    input logic has_d, output logic [7:0] r);
    start(mode3);
    byte_x(op, r);
    if (has_d) byte_x(d, r);
    stop();
  endtask
endmodule

`default_nettype wire

//--- dv/testbench.sv
// Purpose: self-checking bench for the serial command front end
// Assumes: 50 MHz clock, host model drives pins at falling edges
// Notes: popped queue entries are collected for comparison
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic cmd_ready = 1'b1;
  wire logic cs_n, sck, si, hold_n, wp_n, so_out, so_oe_n, sleeping, cmd_valid;
  wire logic [7:0] status_out, cmd_code;
  int fails = 0;
  int comparisons = 0;
  logic [7:0] got[$];
  logic [7:0] r;
  logic [7:0] slp [2] = '{8'hba, 8'hb9};
  logic [7:0] fq [6] = '{8'h06, 8'h03, 8'h0b, 8'h9f, 8'h4c, 8'hc3};
  // op-code, queued, latch after
  logic [9:0] rows [18] = '{10'h01b, 10'h012, 10'h008, 10'h108, 10'h308, 10'h01b,
    10'h00b, 10'h10b, 10'h30b, 10'h00f, 10'h02f, 10'h27f, 10'h133, 10'h30f, 10'h12f,
    10'h127, 10'h007, 10'h012};

  // ----------------------------------------
  // clock, design and host
  // ----------------------------------------
  always #10 clk = ~clk;
  always @(posedge clk) if (cmd_valid && cmd_ready) got.push_back(cmd_code);

  sfc_front_end dut (.clk(clk), .nrst(nrst), .ce(ce), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe_n(so_oe_n),
    .status_out(status_out), .sleeping(sleeping), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_ready(cmd_ready));
  sfc_host host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
    .wp_n(wp_n), .so_out(so_out), .so_oe_n(so_oe_n));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic tend(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic sw(input logic [7:0] d);
    host.cmd(1'b0, sfc_pkg::cmd_status_write, d, 1'b1, r);
  endtask

  task automatic results();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    results();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    foreach (rows[i]) begin
      got.delete();
      host.cmd(i[0], rows[i][9:2], 8'h00, 1'b0, r);
      chk8("queued", {7'h0, rows[i][1]}, 8'(got.size()));
      if (rows[i][1]) chk8("code", rows[i][9:2], got[0]);
      chk8("latch", {7'h0, rows[i][0]}, {7'h0, status_out[1]});
    end
    tend("table");
    host.cmd(1'b0, sfc_pkg::cmd_set_write_latch, 8'h00, 1'b0, r);
    sw(8'hff);
    chk8("status", 8'hfe, status_out);
    host.set_wp(1'b0);
    sw(8'h00);
    chk8("status", 8'hfe, status_out);
    host.set_wp(1'b1);
    sw(8'hb3);
    chk8("status", 8'hb2, status_out);
    host.cmd(1'b1, sfc_pkg::cmd_status_read, 8'h00, 1'b1, r);
    chk8("read3", 8'hb2, r);
    host.cmd(1'b0, sfc_pkg::cmd_status_read, 8'h00, 1'b1, r);
    chk8("read0", 8'hb2, r);
    chk8("so_oe_n", 8'h01, {7'h0, so_oe_n});
    host.cmd(1'b0, sfc_pkg::cmd_clear_write_latch, 8'h00, 1'b0, r);
    sw(8'h4c);
    chk8("status", 8'hb0, status_out);
    tend("status");
    got.delete();
    host.start(1'b0);
    host.nib(4'h0, r[3:0]);
    host.stop();
    host.cmd(1'b0, sfc_pkg::cmd_set_write_latch, 8'h00, 1'b0, r);
    chk8("count", 8'h01, 8'(got.size()));
    chk8("code", 8'h06, got[0]);
    host.start(1'b0);
    host.nib(4'h0, r[3:0]);
    host.pause();
    host.nib(4'h4, r[3:0]);
    host.stop();
    chk8("latch", 8'h00, {7'h0, status_out[1]});
    tend("partial and hold");
    foreach (slp[i]) begin
      host.cmd(1'b0, sfc_pkg::cmd_set_write_latch, 8'h00, 1'b0, r);
      host.cmd(i[0], slp[i], 8'h00, 1'b0, r);
      chk8("sleeping", 8'h01, {7'h0, sleeping});
      host.cmd(1'b0, sfc_pkg::cmd_set_write_latch, 8'h00, 1'b0, r);
      chk8("sleeping", 8'h00, {7'h0, sleeping});
      chk8("latch", 8'h00, {7'h0, status_out[1]});
    end
    tend("sleep");
    got.delete();
    cmd_ready = 1'b0;
    foreach (fq[i]) host.cmd(1'b0, fq[i], 8'h00, 1'b0, r);
    chk8("cmd_valid", 8'h01, {7'h0, cmd_valid});
    cmd_ready = 1'b1;
    repeat (20) @(negedge clk);
    chk8("count", 8'h05, 8'(got.size()));
    for (int i = 0; i < 5; i++) chk8("code", fq[i], got[i]);
    tend("queue");
    ce = 1'b0;
    host.cmd(1'b0, sfc_pkg::cmd_clear_write_latch, 8'h00, 1'b0, r);
    ce = 1'b1;
    repeat (4) @(negedge clk);
    chk8("latch", 8'h01, {7'h0, status_out[1]});
    chk8("count", 8'h05, 8'(got.size()));
    tend("enable");
    nrst = 1'b0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    chk8("status", 8'h00, status_out);
    chk8("so_oe_n", 8'h01, {7'h0, so_oe_n});
    chk8("cmd_valid", 8'h00, {7'h0, cmd_valid});
    chk8("sleeping", 8'h00, {7'h0, sleeping});
    tend("reset");
    results();
  end
endmodule

`default_nettype wire
